// *** dma_device.sv ***
// Four-channel DMA controller, pin-level behaviour.
// Assumes the host end on LINK and peripherals on the request lines.
//
// The AHB-Lite interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "dma_pins_regs.svh"

module dma_device (
  // Clock and reset
  input  wire logic                CLOCK,
  input  wire logic                RST,
  // Host, bus owner and memory side
  dma_link_if.device               LINK,
  // Peripheral handshake
  input  wire dma_pins_pkg::nib_t  CHANNEL_REQUEST,
  output var  dma_pins_pkg::nib_t  CHANNEL_ACKNOWLEDGE
);
  import dma_pins_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  dev_state_e  state_q, state_d;
  nib_t        req_meta_q, req_sync_q;
  byte_t       cmd_q, temp_q;
  nib_t        tc_q, sw_req_q, mask_q;
  logic        byte_ptr_q;
  logic [1:0]  mode_cnt_q;
  logic [1:0]  mode_q [4];
  logic [15:0] chan_addr_q [4];
  logic [1:0]  chan_q;
  logic        m2m_q, pass_q;
  logic        iow_prev_q, ior_prev_q;

  // ----------------------------------------------------------------
  // Host access decode
  // ----------------------------------------------------------------
  logic  idle, host_rd, wr_evt, rd_evt, clear_all;
  nib_t  ra, pending;
  byte_t wd, rd_mux;
  assign idle    = (state_q == S_IDLE);
  assign ra      = LINK.low_address_lines;
  assign wd      = LINK.shared_data_bus;
  assign host_rd = idle && !LINK.host_select_n && !LINK.io_read_strobe_n;
  assign wr_evt  = idle && !LINK.host_select_n && iow_prev_q && !LINK.io_write_strobe_n;
  assign rd_evt  = host_rd && ior_prev_q;
  assign clear_all = RST || (wr_evt && ra == `DEV_MCLR_TEMP);

  always_comb begin
    case (ra)
      `DEV_CMD_STAT:  rd_mux = {pending, tc_q};
      `DEV_MODE:      rd_mux = {6'h00, mode_cnt_q};
      `DEV_MCLR_TEMP: rd_mux = temp_q;
      `DEV_MASK_ALL:  rd_mux = {4'h0, mask_q};
      default: begin
        if (ra <= `DEV_ADDR_LAST) begin
          rd_mux = byte_ptr_q ? chan_addr_q[ra[2:1]][15:8] : chan_addr_q[ra[2:1]][7:0];
        end else begin
          rd_mux = 8'h00;
        end
      end
    endcase
  end

  // Strobes are plain synchronous inputs; edge memory only here
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      iow_prev_q <= 1'b1;
      ior_prev_q <= 1'b1;
    end else begin
      iow_prev_q <= LINK.io_write_strobe_n;
      ior_prev_q <= LINK.io_read_strobe_n;
    end
  end

  // ----------------------------------------------------------------
  // Programmed registers
  // ----------------------------------------------------------------
  // All state in edge-triggered flops; a stopped clock loses nothing
  always_ff @(posedge CLOCK) begin
    if (clear_all) begin
      cmd_q      <= `CMD_RESET;
      sw_req_q   <= 4'h0;
      mask_q     <= `MASK_RESET;
      byte_ptr_q <= 1'b0;
      mode_cnt_q <= 2'h0;
    end else begin
      if (wr_evt) begin
        case (ra)
          `DEV_CMD_STAT: cmd_q <= wd;
          `DEV_REQUEST:  sw_req_q[wd[`SEL_CH_LSB +: 2]] <= wd[`SEL_SET_BIT];
          `DEV_MASK_ONE: mask_q[wd[`SEL_CH_LSB +: 2]] <= wd[`SEL_SET_BIT];
          `DEV_MODE:     mode_cnt_q <= mode_cnt_q + 2'h1;
          `DEV_CLR_PTR:  byte_ptr_q <= 1'b0;
          `DEV_MASK_CLR: mask_q <= 4'h0;
          `DEV_MASK_ALL: mask_q <= wd[3:0];
          default:       byte_ptr_q <= ~byte_ptr_q;
        endcase
      end else if (rd_evt && ra <= `DEV_ADDR_LAST) begin
        byte_ptr_q <= ~byte_ptr_q;
      end
      if (state_q == S_END && !(m2m_q && !pass_q)) begin
        sw_req_q[chan_q] <= 1'b0;
      end
    end
  end

  // Mode and address arrays are not reset-cleared
  always_ff @(posedge CLOCK) begin
    if (wr_evt && ra == `DEV_MODE) begin
      mode_q[wd[`SEL_CH_LSB +: 2]] <= wd[`MODE_TYPE_LSB +: 2];
    end
    if (wr_evt && ra <= `DEV_ADDR_LAST && !ra[0]) begin
      if (byte_ptr_q) begin
        chan_addr_q[ra[2:1]][15:8] <= wd;
      end else begin
        chan_addr_q[ra[2:1]][7:0] <= wd;
      end
    end
  end

  // Service-done flags; a completion beats a status-read clear
  always_ff @(posedge CLOCK) begin
    if (clear_all) begin
      tc_q <= 4'h0;
    end else begin
      tc_q <= ((rd_evt && ra == `DEV_CMD_STAT) ? 4'h0 : tc_q) |
              ((state_q == S_END && !(m2m_q && !pass_q)) ? (4'h1 << chan_q) : 4'h0);
    end
  end

  // ----------------------------------------------------------------
  // Request recognition
  // ----------------------------------------------------------------
  // Requests arrive asynchronously; sampled only on clock edges
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      req_meta_q <= 4'h0;
      req_sync_q <= 4'h0;
    end else begin
      req_meta_q <= CHANNEL_REQUEST;
      req_sync_q <= req_meta_q;
    end
  end

  logic [1:0] winner;
  assign pending = ((req_sync_q ^ {4{cmd_q[`CMD_REQ_LOW_BIT]}}) & ~mask_q) | sw_req_q;
  always_comb begin
    winner = 2'd3;
    for (int i = 3; i >= 0; i--) begin
      if (pending[i]) begin
        winner = i[1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Transfer sequencer
  // ----------------------------------------------------------------
  xfer_e xtype;
  logic  is_verify;
  assign xtype     = m2m_q ? (pass_q ? XF_WRITE : XF_READ) : xfer_e'(mode_q[chan_q]);
  assign is_verify = !m2m_q && (xtype == XF_VERIFY || xtype == XF_SPARE);

  always_comb begin
    state_d = state_q;
    case (state_q)
      S_IDLE: begin
        if (|pending && !cmd_q[`CMD_DISABLE_BIT] && !LINK.bus_grant_ack) begin
          state_d = S_HOLD;
        end
      end
      S_HOLD: begin
        if (LINK.bus_grant_ack) begin
          state_d = S_ADDR;
        end
      end
      S_ADDR: state_d = S_XFER;
      S_XFER: state_d = S_WAIT;
      S_WAIT: begin
        if (LINK.ready || is_verify) begin
          state_d = S_END;
        end
      end
      S_END:   state_d = (m2m_q && !pass_q) ? S_ADDR : S_IDLE;
      default: state_d = S_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (clear_all) begin
      state_q <= S_IDLE;
      chan_q  <= 2'd0;
      m2m_q   <= 1'b0;
      pass_q  <= 1'b0;
      temp_q  <= 8'h00;
    end else begin
      state_q <= state_d;
      if (state_q == S_IDLE && state_d == S_HOLD) begin
        chan_q <= winner;
        m2m_q  <= cmd_q[`CMD_M2M_BIT] && winner == 2'd0;
        pass_q <= 1'b0;
      end
      if (state_q == S_END) begin
        pass_q <= 1'b1;
      end
      if (state_q == S_WAIT && state_d == S_END && m2m_q && !pass_q) begin
        temp_q <= LINK.shared_data_bus;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin drive, registered from the next state
  // ----------------------------------------------------------------
  logic        act_d, strb_d;
  logic [15:0] cur_addr;
  assign act_d    = (state_d == S_ADDR) || (state_d == S_XFER) || (state_d == S_WAIT);
  assign strb_d   = (state_d == S_XFER) || (state_d == S_WAIT);
  assign cur_addr = (m2m_q && pass_q) ? chan_addr_q[1] : chan_addr_q[chan_q];

  always_ff @(posedge CLOCK) begin
    if (clear_all) begin
      LINK.bus_hold_request     <= 1'b0;
      LINK.upper_address_strobe <= 1'b0;
      LINK.dev_addr_o           <= 4'h0;
      LINK.dev_addr_oe          <= 1'b0;
      LINK.dev_db_o             <= 8'h00;
      LINK.dev_db_oe            <= 1'b0;
      LINK.dev_ior_o            <= 1'b1;
      LINK.dev_ior_oe           <= 1'b0;
      LINK.dev_iow_o            <= 1'b1;
      LINK.dev_iow_oe           <= 1'b0;
      LINK.mem_read_strobe_n    <= 1'b1;
      LINK.mem_write_strobe_n   <= 1'b1;
      CHANNEL_ACKNOWLEDGE       <= 4'h0;
    end else begin
      LINK.bus_hold_request     <= (state_d != S_IDLE);
      LINK.upper_address_strobe <= (state_d == S_ADDR);
      LINK.dev_addr_o           <= cur_addr[3:0];
      LINK.dev_addr_oe          <= act_d;
      if (state_d == S_ADDR) begin
        LINK.dev_db_o  <= cur_addr[15:8];
        LINK.dev_db_oe <= 1'b1;
      end else if (strb_d && m2m_q && pass_q) begin
        LINK.dev_db_o  <= temp_q;
        LINK.dev_db_oe <= 1'b1;
      end else begin
        // Byte frozen at the strobe edge; pointer and done flags move then
        if (rd_evt || !host_rd) begin
          LINK.dev_db_o <= rd_mux;
        end
        LINK.dev_db_oe <= host_rd && state_d == S_IDLE;
      end
      // Strobes driven only while active; idle leaves them to the host
      LINK.dev_ior_oe <= act_d;
      LINK.dev_iow_oe <= act_d;
      LINK.dev_ior_o  <= !(strb_d && !m2m_q && xtype == XF_WRITE);
      LINK.dev_iow_o  <= !(strb_d && !m2m_q && xtype == XF_READ);
      LINK.mem_read_strobe_n  <= !(strb_d && xtype == XF_READ);
      LINK.mem_write_strobe_n <= !(strb_d && xtype == XF_WRITE);
      CHANNEL_ACKNOWLEDGE     <= (act_d && !m2m_q) ? (4'h1 << chan_q) : 4'h0;
    end
  end
endmodule : dma_device
`default_nettype wire

// *** dma_host.sv ***
// Host CPU, bus owner and memory end of the DMA link.
// Assumes software on AHB-Lite and the controller on LINK.
`timescale 1ns/10ps
`default_nettype none
`include "dma_pins_regs.svh"
module dma_host (
  // Clock and reset
  input  wire logic                 CLOCK,
  input  wire logic                 RST,
  // AHB-Lite slave
  input  wire logic                 HSEL,
  input  wire logic [7:0]           HADDR,
  input  wire logic [1:0]           HTRANS,
  input  wire logic                 HWRITE,
  input  wire logic [2:0]           HSIZE,
  input  wire dma_pins_pkg::word_t  HWDATA,
  input  wire logic                 HREADY,
  output var  dma_pins_pkg::word_t  HRDATA,
  output var  logic                 HREADYOUT,
  output var  logic                 HRESP,
  // Controller link
  dma_link_if.host                  LINK
);
  import dma_pins_pkg::*;

  // ----------------------------------------------------------------
  // AHB-Lite register slave
  // ----------------------------------------------------------------
  host_state_e st_q;
  logic        wr_pend_q, go_q, cmd_wr_q, grant_en, rel_q;
  logic [7:0]  wa_q;
  logic [11:0] cmd_q;
  word_t       cfg_q, stat;
  byte_t       rdata_q, upper_q, cap_q, mem_q;
  logic [3:0]  wait_cnt_q;
  logic [1:0]  strb_cnt_q;
  logic        take, cmd_hit;

  assign take     = HSEL && HTRANS[1] && HREADY;
  assign cmd_hit  = wr_pend_q && wa_q == `H_CMD_OFS;
  assign grant_en = cfg_q[`H_CFG_GRANT_BIT];
  assign stat     = {cap_q, upper_q, rdata_q, 5'h00, LINK.bus_grant_ack,
                     LINK.bus_hold_request, (st_q != H_IDLE) || go_q};

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      wr_pend_q <= 1'b0;
      wa_q      <= 8'h00;
      HRDATA    <= 32'h0000_0000;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
      cfg_q     <= `H_CFG_RESET;
      mem_q     <= 8'h00;
      cmd_q     <= 12'h000;
      cmd_wr_q  <= 1'b0;
    end else begin
      wr_pend_q <= take && HWRITE;
      wa_q      <= HADDR;
      if (take && !HWRITE) begin
        case (HADDR)
          `H_CMD_OFS:  HRDATA <= {19'h0_0000, cmd_wr_q, cmd_q};
          `H_STAT_OFS: HRDATA <= stat;
          `H_CFG_OFS:  HRDATA <= cfg_q;
          `H_MEM_OFS:  HRDATA <= {24'h00_0000, mem_q};
          default:     HRDATA <= 32'h0000_0000;
        endcase
      end
      if (wr_pend_q && wa_q == `H_CFG_OFS) begin
        cfg_q <= HWDATA;
      end
      if (wr_pend_q && wa_q == `H_MEM_OFS) begin
        mem_q <= HWDATA[7:0];
      end
      if (cmd_hit && st_q == H_IDLE && !go_q) begin
        cmd_q    <= HWDATA[11:0];
        cmd_wr_q <= HWDATA[`H_CMD_WR_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Register access sequencer on the idle controller
  // ----------------------------------------------------------------
  logic drive;
  assign drive = (st_q != H_IDLE);

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      st_q       <= H_IDLE;
      go_q       <= 1'b0;
      strb_cnt_q <= 2'h0;
      rdata_q    <= 8'h00;
    end else begin
      case (st_q)
        H_IDLE: begin
          if (cmd_hit && !go_q) begin
            go_q <= 1'b1;
          end else if (go_q && !LINK.bus_hold_request && !LINK.bus_grant_ack) begin
            go_q <= 1'b0;
            st_q <= H_SETUP;
          end
        end
        H_SETUP: begin
          strb_cnt_q <= 2'h0;
          st_q       <= H_STROBE;
        end
        H_STROBE: begin
          strb_cnt_q <= strb_cnt_q + 2'h1;
          if (strb_cnt_q == `H_STROBE_CYC) begin
            rdata_q <= LINK.shared_data_bus;
            st_q    <= H_DONE;
          end
        end
        H_DONE:  st_q <= H_IDLE;
        default: st_q <= H_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Bus ownership, memory model and ready
  // ----------------------------------------------------------------
  logic mem_rd_req, mem_wr;
  assign mem_rd_req = !LINK.mem_read_strobe_n ||
                      (!LINK.io_read_strobe_n && LINK.bus_grant_ack);
  assign mem_wr     = !LINK.mem_write_strobe_n;

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      rel_q              <= 1'b0;
      LINK.bus_grant_ack <= 1'b0;
      LINK.ready         <= 1'b1;
      wait_cnt_q         <= 4'h0;
      upper_q            <= 8'h00;
      cap_q              <= 8'h00;
      LINK.host_select_n <= 1'b1;
      LINK.host_addr_o   <= 4'h0;
      LINK.host_addr_oe  <= 1'b0;
      LINK.host_ior_o    <= 1'b1;
      LINK.host_ior_oe   <= 1'b0;
      LINK.host_iow_o    <= 1'b1;
      LINK.host_iow_oe   <= 1'b0;
      LINK.host_db_o     <= 8'h00;
      LINK.host_db_oe    <= 1'b0;
    end else begin
      // One fully released cycle precedes any grant
      rel_q              <= (st_q == H_IDLE);
      LINK.bus_grant_ack <= grant_en && LINK.bus_hold_request &&
                            (LINK.bus_grant_ack || (st_q == H_IDLE && rel_q && !go_q));
      // Waits counted in every granted cycle past the address cycle, verify included, though verify does not wait for ready
      if (LINK.bus_grant_ack && LINK.bus_hold_request && !LINK.upper_address_strobe) begin
        LINK.ready <= (wait_cnt_q >= cfg_q[7:4]);
        wait_cnt_q <= (wait_cnt_q >= cfg_q[7:4]) ? wait_cnt_q : wait_cnt_q + 4'h1;
      end else begin
        LINK.ready <= 1'b1;
        wait_cnt_q <= 4'h0;
      end
      if (LINK.upper_address_strobe) begin
        upper_q <= LINK.shared_data_bus;
      end
      if (mem_wr) begin
        cap_q <= LINK.shared_data_bus;
      end
      LINK.host_select_n <= !(drive && st_q != H_DONE);
      LINK.host_addr_o   <= cmd_q[11:8];
      LINK.host_addr_oe  <= drive;
      LINK.host_ior_oe   <= drive;
      LINK.host_iow_oe   <= drive;
      LINK.host_ior_o    <= !(st_q == H_SETUP || (st_q == H_STROBE && strb_cnt_q != `H_STROBE_CYC)) || cmd_wr_q;
      LINK.host_iow_o    <= !(st_q == H_SETUP || (st_q == H_STROBE && strb_cnt_q != `H_STROBE_CYC)) || !cmd_wr_q;
      LINK.host_db_o     <= drive ? cmd_q[7:0] : mem_q;
      LINK.host_db_oe    <= (drive && cmd_wr_q) || (mem_rd_req && !LINK.upper_address_strobe);
    end
  end
endmodule : dma_host
`default_nettype wire

// *** dma_link_if.sv ***
// Pin bundle between the DMA controller and its host / bus owner.
// Assumes both ends clock on the same edge; shared wires resolve here.
`timescale 1ns/10ps
`default_nettype none
`include "dma_pins_regs.svh"
interface dma_link_if;
  import dma_pins_pkg::*;
  // Driven by the controller
  byte_t dev_db_o;
  logic  dev_db_oe;
  nib_t  dev_addr_o;
  logic  dev_addr_oe;
  logic  dev_ior_o;
  logic  dev_ior_oe;
  logic  dev_iow_o;
  logic  dev_iow_oe;
  logic  bus_hold_request;
  logic  upper_address_strobe;
  logic  mem_read_strobe_n;
  logic  mem_write_strobe_n;
  // Driven by the host / bus owner
  byte_t host_db_o;
  logic  host_db_oe;
  nib_t  host_addr_o;
  logic  host_addr_oe;
  logic  host_ior_o;
  logic  host_ior_oe;
  logic  host_iow_o;
  logic  host_iow_oe;
  logic  host_select_n;
  logic  bus_grant_ack;
  logic  ready;
  // Resolved wires, pulled up when nobody drives
  byte_t shared_data_bus;
  nib_t  low_address_lines;
  logic  io_read_strobe_n;
  logic  io_write_strobe_n;

  assign shared_data_bus   = dev_db_oe ? dev_db_o : (host_db_oe ? host_db_o : `BUS_FLOAT);
  assign low_address_lines = dev_addr_oe ? dev_addr_o : (host_addr_oe ? host_addr_o : `ADDR_FLOAT);
  assign io_read_strobe_n  = dev_ior_oe ? dev_ior_o : (host_ior_oe ? host_ior_o : 1'b1);
  assign io_write_strobe_n = dev_iow_oe ? dev_iow_o : (host_iow_oe ? host_iow_o : 1'b1);

  modport device (
    output dev_db_o, dev_db_oe, dev_addr_o, dev_addr_oe, dev_ior_o, dev_ior_oe,
    output dev_iow_o, dev_iow_oe, bus_hold_request, upper_address_strobe,
    output mem_read_strobe_n, mem_write_strobe_n,
    input  host_select_n, bus_grant_ack, ready,
    input  shared_data_bus, low_address_lines, io_read_strobe_n, io_write_strobe_n
  );
  modport host (
    output host_db_o, host_db_oe, host_addr_o, host_addr_oe, host_ior_o, host_ior_oe,
    output host_iow_o, host_iow_oe, host_select_n, bus_grant_ack, ready,
    input  bus_hold_request, upper_address_strobe, mem_read_strobe_n, mem_write_strobe_n,
    input  shared_data_bus, low_address_lines, io_read_strobe_n, io_write_strobe_n
  );
endinterface : dma_link_if
`default_nettype wire

// *** dma_link_monitor.sv ***
// Link-pin assertions for the controller and its host end.
// Assumes one clock domain and is placed beside the link.
`timescale 1ns/10ps
`default_nettype none
module dma_link_monitor (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Link pins
  input wire logic bus_hold_request,
  input wire logic bus_grant_ack,
  input wire logic upper_address_strobe,
  input wire logic dev_db_oe,
  input wire logic dev_addr_oe,
  input wire logic dev_ior_oe,
  input wire logic dev_iow_oe,
  input wire logic mem_read_strobe_n,
  input wire logic mem_write_strobe_n,
  input wire logic ready,
  input wire logic host_select_n,
  input wire logic io_read_strobe_n,
  input wire logic io_write_strobe_n,
  // Peripheral side
  input wire dma_pins_pkg::nib_t channel_acknowledge
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  chk_reset_idle: assert property ($fell(rst) |-> !bus_hold_request && channel_acknowledge == 4'h0 && !dev_db_oe)
    else $error("link not idle after reset");
  chk_idle_no_drive: assert property (!bus_hold_request |-> !dev_ior_oe && !dev_iow_oe && !dev_addr_oe)
    else $error("strobe or address driven while idle");
  chk_read_needs_sel: assert property ($rose(dev_db_oe) && !bus_hold_request
    |-> !$past(host_select_n) && !$past(io_read_strobe_n))
    else $error("data bus driven without selected read");
  chk_write_floats_bus: assert property (!io_write_strobe_n && !host_select_n && !bus_hold_request |-> !dev_db_oe)
    else $error("data bus driven during host write");
  chk_ack_needs_grant: assert property (|channel_acknowledge |-> bus_grant_ack && bus_hold_request)
    else $error("acknowledge without grant");
  chk_active_drives_pins: assert property (dev_addr_oe |-> dev_ior_oe && dev_iow_oe && bus_hold_request)
    else $error("active cycle without strobe drive");
  chk_ack_one_hot: assert property ($onehot0(channel_acknowledge))
    else $error("more than one acknowledge");
  chk_strobe_drives_addr: assert property (upper_address_strobe |-> dev_db_oe && dev_addr_oe && bus_grant_ack)
    else $error("address strobe without address out");
  chk_ready_stretch_rd: assert property (!mem_read_strobe_n && !ready |=> !mem_read_strobe_n)
    else $error("memory read not stretched");
  chk_ready_stretch_wr: assert property (!mem_write_strobe_n && !ready |=> !mem_write_strobe_n)
    else $error("memory write not stretched");
endmodule : dma_link_monitor
`default_nettype wire

// *** dma_pins_pkg.sv ***
// Types shared by the DMA controller pair.
// Assumes nothing beyond a SystemVerilog compiler.
package dma_pins_pkg;
  typedef logic [3:0]  nib_t;
  typedef logic [7:0]  byte_t;
  typedef logic [31:0] word_t;
  typedef enum logic [1:0] {XF_VERIFY, XF_WRITE, XF_READ, XF_SPARE} xfer_e;
  typedef enum {S_IDLE, S_HOLD, S_ADDR, S_XFER, S_WAIT, S_END} dev_state_e;
  typedef enum {H_IDLE, H_SETUP, H_STROBE, H_DONE} host_state_e;
endpackage : dma_pins_pkg

// *** dma_pins_regs.svh ***
// Constants for the DMA pin-level controller and its host-side partner.
// Assumes inclusion by bare name from every file of the pair.
`ifndef DMA_PINS_REGS_SVH
`define DMA_PINS_REGS_SVH

// ----------------------------------------------------------------
// Device register indices on the low address lines
// ----------------------------------------------------------------
`define DEV_ADDR_LAST   4'h7
`define DEV_CMD_STAT    4'h8
`define DEV_REQUEST     4'h9
`define DEV_MASK_ONE    4'hA
`define DEV_MODE        4'hB
`define DEV_CLR_PTR     4'hC
`define DEV_MCLR_TEMP   4'hD
`define DEV_MASK_CLR    4'hE
`define DEV_MASK_ALL    4'hF

// ----------------------------------------------------------------
// Device fields and reset values
// ----------------------------------------------------------------
`define CMD_M2M_BIT     0
`define CMD_DISABLE_BIT 2
`define CMD_REQ_LOW_BIT 6
`define SEL_CH_LSB      0
`define SEL_SET_BIT     2
`define MODE_TYPE_LSB   2
`define CMD_RESET       8'h00
`define MASK_RESET      4'hF
`define BUS_FLOAT       8'hFF
`define ADDR_FLOAT      4'hF

// ----------------------------------------------------------------
// Host AHB register offsets, fields and timing
// ----------------------------------------------------------------
`define H_CMD_OFS       8'h00
`define H_STAT_OFS      8'h04
`define H_CFG_OFS       8'h08
`define H_MEM_OFS       8'h0C
`define H_CMD_WR_BIT    12
`define H_CFG_GRANT_BIT 0
`define H_CFG_RESET     32'h0000_0001
`define H_STROBE_CYC    2'h2

`endif

// *** testbench.sv ***
// Controller and host end joined on one link; software speaks AHB-Lite.
// Assumes package, header, interface and both ends compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "dma_pins_regs.svh"
module testbench;
  import dma_pins_pkg::*;
  logic clock = 0, rst = 1, hsel = 0, hwrite = 0, hready, hresp;
  logic [7:0] haddr = 0;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 0;
  word_t hwdata = 0, hrdata, s;
  nib_t req = 0, ack;
  byte_t r, m, hb;
  int fails = 0, tests_run = 0, cyc = 0, hold_cyc = 0, n, d0, seed = 32'h0000_4ab1;
  dma_link_if link();
  dma_device u_dma_device(.CLOCK(clock), .RST(rst), .LINK(link), .CHANNEL_REQUEST(req), .CHANNEL_ACKNOWLEDGE(ack));
  dma_host u_dma_host(.CLOCK(clock), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .LINK(link));
  dma_link_monitor u_mon(.clock(clock), .rst(rst), .bus_hold_request(link.bus_hold_request),
    .bus_grant_ack(link.bus_grant_ack), .upper_address_strobe(link.upper_address_strobe),
    .dev_db_oe(link.dev_db_oe), .dev_addr_oe(link.dev_addr_oe), .dev_ior_oe(link.dev_ior_oe),
    .dev_iow_oe(link.dev_iow_oe), .mem_read_strobe_n(link.mem_read_strobe_n), .ready(link.ready),
    .mem_write_strobe_n(link.mem_write_strobe_n), .host_select_n(link.host_select_n),
    .io_read_strobe_n(link.io_read_strobe_n), .io_write_strobe_n(link.io_write_strobe_n),
    .channel_acknowledge(ack));
  initial forever #5 clock = ~clock;
  always @(posedge clock) begin
    cyc++;
    if (link.bus_hold_request === 1'b1) hold_cyc++;
    if (cyc == 20000) begin
      fails++;
      end_sim();
    end
  end
  task end_sim;
    $display("Checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim
  task chk(input word_t got, input word_t exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task ahb(input logic w, input logic [7:0] a, input word_t wd);
    @(posedge clock);
    hsel <= 1; htrans <= 2'b10; haddr <= a; hwrite <= w; hsize <= 3'b010;
    do @(posedge clock); while (hready !== 1'b1);
    hsel <= 0; htrans <= 2'b00; hwdata <= wd;
    do @(posedge clock); while (hready !== 1'b1);
    s = hrdata;
  endtask : ahb
  // Polls status until access, hold and grant have all dropped
  task idle;
    n = 0;
    repeat (3) @(posedge clock);
    do begin ahb(0, `H_STAT_OFS, 0); n++; end while (s[2:0] !== 3'b000 && n < 60);
  endtask : idle
  task dev(input logic w, input nib_t i, input byte_t d);
    ahb(1, `H_CMD_OFS, {19'h0, w, i, d});
    idle();
    r = s[15:8];
  endtask : dev
  function automatic nib_t first(nib_t v);
    return v & (~v + 4'h1);
  endfunction : first
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    for (int p = 0; p < 2; p++) begin
      @(posedge clock); rst <= 1; repeat (10) @(posedge clock); rst <= 0;
      ahb(0, `H_CFG_OFS, 0); chk(s, `H_CFG_RESET);
      dev(0, 4'h8, 0); chk(r, 0);
      dev(0, 4'hB, 0); chk(r, 0);
      dev(0, 4'hD, 0); chk(r, 0);
      dev(0, 4'hF, 0); chk(r, 4'hF);
      for (int c = 0; c < 5; c++) dev(1, 4'hB, {4'h0, 2'b01, 2'(c)});
    end
    ahb(0, 8'h10, 0); chk(s, 0);
    for (int k = 0; k < 6; k++) begin
      if (k == 4) begin
        dev(1, 4'hF, 8'h0F); req <= 4'hF; dev(1, 4'h8, 8'h40);
      end
      m = (k == 2) ? 8'h00 : 8'($random(seed));
      hb = (k == 1) ? 8'hFF : 8'($random(seed));
      dev(1, 4'hF, m & 8'h0F); dev(0, 4'hF, 0); chk(r, m & 8'h0F);
      @(posedge clock); req <= (k > 3) ? ~hb[3:0] : hb[3:0];
      n = 0;
      while (ack === 4'h0 && n < 40) begin @(posedge clock); n++; end
      chk(ack, first(hb[3:0] & ~m[3:0]));
      req <= (k > 3) ? 4'hF : 4'h0;
      idle();
    end
    dev(1, 4'hF, 8'h0F); req <= 4'h0; dev(1, 4'h8, 8'h00);
    dev(1, 4'hC, 0); dev(1, 4'h4, 8'($random(seed))); hb = 8'($random(seed)); dev(1, 4'h4, hb);
    dev(0, 4'h8, 0);
    // Wait states show as extra hold cycles, except in verify
    for (int i = 0; i < 4; i++) begin
      ahb(1, `H_CFG_OFS, i[0] ? 32'h0000_0031 : 32'h0000_0001);
      dev(1, 4'hB, {4'h0, i[1] ? 2'b10 : 2'b00, 2'b10});
      hold_cyc = 0; dev(1, 4'h9, 8'h06);
      if (i[0]) chk(hold_cyc - d0, i[1] ? 3 : 0);
      else d0 = hold_cyc;
      ahb(0, `H_STAT_OFS, 0); chk(s[23:16], hb);
    end
    dev(0, 4'h8, 0); chk(r, 8'h04);
    dev(0, 4'h8, 0); chk(r, 8'h00);
    m = 8'($random(seed)); ahb(1, `H_MEM_OFS, {24'h0, m});
    dev(1, 4'h8, 8'h01); dev(1, 4'h9, 8'h04);
    ahb(0, `H_STAT_OFS, 0); chk(s[31:24], m);
    dev(0, 4'hD, 0); chk(r, m);
    end_sim();
  end
endmodule : testbench
`default_nettype wire
